// ### design/pcg_params.svh
// Register offsets, field positions, reset values and counts for pad/port block
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH

// Port geometry
`define PCG_NPINS 12
`define PCG_NWAKE 11
`define PCG_PORT_IRQ_LINE 31

// Register byte offsets: pad config 0x000..0x02C, port block from 0x100
`define PCG_PAD_BASE 12'h000
`define PCG_PORT_DATA 12'h100
`define PCG_PORT_MASK 12'h104
`define PCG_PORT_MDATA 12'h108
`define PCG_PORT_SET 12'h10C
`define PCG_PORT_CLR 12'h110
`define PCG_PORT_TGL 12'h114
`define PCG_PORT_DIR 12'h118
`define PCG_DIR_SET 12'h11C
`define PCG_DIR_CLR 12'h120
`define PCG_DIR_TGL 12'h124
`define PCG_IRQ_EN 12'h128
`define PCG_IRQ_STAT 12'h12C

// Pad config field positions
`define PCG_F_PIN_FUNCTION_SELECT_LO 0
`define PCG_F_MODE_LO 3
`define PCG_F_HYS 5
`define PCG_F_INV 6
`define PCG_F_OD 7
`define PCG_F_I2C_LO 8
`define PCG_F_SINK 10
`define PCG_F_ILO_LO 11
`define PCG_F_IHI_LO 16
`define PCG_PAD_BITS 21

// Reset values: GPIO, no pull; bus pads in bus function; debug pads debug
`define PCG_PAD_RST 21'h000000
`define PCG_PAD_RST_BUS 21'h000001
`define PCG_PAD_RST_DBG 21'h000001

// Glitch filter length in clocks (50 ns at 8 ns per clock, rounded up)
`define PCG_GLITCH_NS 50
`define PCG_CLK_NS 8
`define PCG_GLITCH_CYC ((`PCG_GLITCH_NS + `PCG_CLK_NS - 1) / `PCG_CLK_NS)

`endif

// ### design/pcg_pkg.sv
// Types shared by the pad configuration and port logic
package pcg_pkg;

	// Resistor mode
	typedef enum logic [1:0] {
		PCG_PULL_NONE = 2'h0,
		PCG_PULL_DOWN = 2'h1,
		PCG_PULL_UP = 2'h2,
		PCG_REPEATER = 2'h3
	} pcg_pull_e;

	// Bus pad mode
	typedef enum logic [1:0] {
		PCG_BUS_FILTERED = 2'h0,
		PCG_BUS_PLAIN_OD = 2'h1,
		PCG_BUS_RSVD_A = 2'h2,
		PCG_BUS_RSVD_B = 2'h3
	} pcg_bus_e;

	// One pad's configuration word
	typedef struct packed {
		logic [4:0] sink_current_high_level;
		logic [4:0] sink_current_low_level;
		logic sink_mode;
		pcg_bus_e bus_mode;
		logic open_drain;
		logic invert;
		logic hysteresis;
		pcg_pull_e pull;
		logic [2:0] pin_function_select;
	} pcg_pad_s;

	// Per-pad electrical controls toward the pad ring
	typedef struct packed {
		logic pull_up_en;
		logic pull_down_en;
		logic filter_en;
		logic hysteresis;
		logic sink_mode;
		logic [4:0] sink_level;
	} pcg_padctl_s;

endpackage : pcg_pkg

// ### design/pcg_top.sv
// Pad configuration block and general-purpose port with APB register access
//
// Summary of operation
// - Function code 000 selects port, else peripheral
// - Port direction bit sets GPIO pin direction
// - Peripheral pins take direction from the peripheral
// - Resistor mode: pull-up, pull-down, none, repeater
// - Resistor mode resets to no pull
// - Repeater pulls toward the pin's current level
// - Repeater hold need not survive deep power-down
// - Bus pads: filtered bus or plain open-drain
// - High-drive pads: digital or switched current sink
// - Pad config holds input mode and hysteresis
// - GPIO pins may be set open-drain
// - One write sets or clears many bits
// - Masked, set, clear and whole-port writes
// - Registers answer every access in one cycle
// - Direction bits set, clear and toggle
// - Reset: GPIO inputs, no pull, except four pads
// - Each port bit fixed to its own pin
// - Combined port interrupt drives line 31
// - Pins 0 to 10 drive wake lines 0 to 10
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none

// Offsets, field positions, reset values and counts
`include "pcg_params.svh"

module pcg_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pads
	input wire logic [`PCG_NPINS-1:0] pad_in,
	output logic [`PCG_NPINS-1:0] pad_out,
	output logic [`PCG_NPINS-1:0] pad_oe,
	output var pcg_pkg::pcg_padctl_s [`PCG_NPINS-1:0] pad_ctl,
	// Peripheral side
	input wire logic [`PCG_NPINS-1:0] periph_out,
	input wire logic [`PCG_NPINS-1:0] periph_oe,
	output logic [`PCG_NPINS-1:0] periph_in,
	output logic [`PCG_NPINS-1:0] periph_sel,
	// Power state and interrupt lines
	input wire logic deep_pdn,
	output logic [`PCG_NWAKE-1:0] wake_irq,
	output logic port_irq
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// High-drive pads: 3, 7, 10, 11
	function automatic logic is_hd(input int i);
		return (i == 3) || (i == 7) || (i == 10) || (i == 11);
	endfunction : is_hd

	// Bus pads 4 and 5
	function automatic logic is_bus(input int i);
		return (i == 4) || (i == 5);
	endfunction : is_bus

	// Debug pads 10 and 11 wake up in their debug function
	function automatic logic is_dbg(input int i);
		return (i == 10) || (i == 11);
	endfunction : is_dbg

	// Glitch filter in use: bus pad, peripheral function, filtered mode
	function automatic logic bus_filt(input int i,
		input pcg_pkg::pcg_pad_s p);
		return is_bus(i) && (p.pin_function_select != 3'h0)
			&& (p.bus_mode == pcg_pkg::PCG_BUS_FILTERED);
	endfunction : bus_filt

	// Write strobe for one register offset
	function automatic logic reg_wr(input logic en, input logic [11:0] a,
		input logic [11:0] off);
		return en && (a == off);
	endfunction : reg_wr

	// Reset value of each pad's config word
	function automatic logic [`PCG_PAD_BITS-1:0] pad_rst(input int i);
		if (is_bus(i)) begin
			return `PCG_PAD_RST_BUS;
		end
		if (is_dbg(i)) begin
			return `PCG_PAD_RST_DBG;
		end
		return `PCG_PAD_RST;
	endfunction : pad_rst

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	pcg_pkg::pcg_pad_s [`PCG_NPINS-1:0] pad_q;
	logic [`PCG_NPINS-1:0] out_q;
	logic [`PCG_NPINS-1:0] dir_q;
	logic [`PCG_NPINS-1:0] mask_q;
	logic [`PCG_NPINS-1:0] irq_en_q;
	logic [`PCG_NPINS-1:0] in_sync_q;
	logic [`PCG_NPINS-1:0] pin_q;
	logic [`PCG_NPINS-1:0] pin_prev_q;
	logic [`PCG_NPINS-1:0] irq_stat_q;
	logic [`PCG_NPINS-1:0] wdat;
	logic wr_en;
	logic rd_en;
	logic [11:0] addr;
	logic [31:0] rdata_d;
	logic hit;

	assign wdat = pwdata[`PCG_NPINS-1:0];
	assign addr = paddr;
	// Single-cycle access: setup then access, ready always high
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	// ------------------------------------------------------------
	// Pad configuration registers
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `PCG_NPINS; gi++) begin : g_pad
			localparam logic [11:0] OFF = 12'(`PCG_PAD_BASE + gi * 4);
			// Config word; bus and sink fields only kept on pads with them
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pad_q[gi] <= pcg_pkg::pcg_pad_s'(pad_rst(gi));
				end else if (reg_wr(wr_en, addr, OFF)) begin
					pad_q[gi] <= pcg_pkg::pcg_pad_s'(
						pwdata[`PCG_PAD_BITS-1:0]);
					if (!is_bus(gi)) begin
						pad_q[gi].bus_mode <= pcg_pkg::PCG_BUS_FILTERED;
					end
					if (!is_hd(gi)) begin
						pad_q[gi].sink_mode <= 1'b0;
						pad_q[gi].sink_current_low_level <= 5'h00;
						pad_q[gi].sink_current_high_level <= 5'h00;
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Port output and direction
	// ------------------------------------------------------------

	// Output latch: whole, masked, set, clear and toggle writes
	// Reads of the data word show pins, so SET reads back this latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q <= '0;
		end else if (wr_en) begin
			unique case (addr)
				`PCG_PORT_DATA: out_q <= wdat;
				`PCG_PORT_MDATA: out_q <= (out_q & mask_q) | (wdat & ~mask_q);
				`PCG_PORT_SET: out_q <= out_q | wdat;
				`PCG_PORT_CLR: out_q <= out_q & ~wdat;
				`PCG_PORT_TGL: out_q <= out_q ^ wdat;
				default: out_q <= out_q;
			endcase
		end
	end

	// Mask: set bits protect output bits from masked writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= '0;
		end else if (reg_wr(wr_en, addr, `PCG_PORT_MASK)) begin
			mask_q <= wdat;
		end
	end

	// Direction: 1 = output; whole, set, clear, toggle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_q <= '0;
		end else if (wr_en) begin
			unique case (addr)
				`PCG_PORT_DIR: dir_q <= wdat;
				`PCG_DIR_SET: dir_q <= dir_q | wdat;
				`PCG_DIR_CLR: dir_q <= dir_q & ~wdat;
				`PCG_DIR_TGL: dir_q <= dir_q ^ wdat;
				default: dir_q <= dir_q;
			endcase
		end
	end

	// Interrupt enable per pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_q <= '0;
		end else if (reg_wr(wr_en, addr, `PCG_IRQ_EN)) begin
			irq_en_q <= wdat;
		end
	end

	// ------------------------------------------------------------
	// Input path: register, bus-pad glitch filter, edge flags
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_sync_q <= '0;
			pin_prev_q <= '0;
		end else begin
			in_sync_q <= pad_in;
			pin_prev_q <= pin_q;
		end
	end

	// Filter counters; only bus pads in filtered bus mode use them
	generate
		for (gi = 0; gi < `PCG_NPINS; gi++) begin : g_in
			logic [3:0] flt_q;
			logic filt;
			logic lvl;
			// Level handed on, inversion applied before filtering
			assign lvl = in_sync_q[gi] ^ pad_q[gi].invert;
			assign filt = bus_filt(gi, pad_q[gi]);
			// Filtered level only passes after staying stable for the filter time
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flt_q <= 4'h0;
					pin_q[gi] <= 1'b0;
				end else if (!filt || lvl == pin_q[gi]) begin
					flt_q <= 4'h0;
					pin_q[gi] <= lvl;
				end else if (flt_q == 4'(`PCG_GLITCH_CYC - 1)) begin
					flt_q <= 4'h0;
					pin_q[gi] <= lvl;
				end else begin
					flt_q <= flt_q + 4'h1;
				end
			end
		end
	endgenerate

	// Sticky edge status; a new edge wins over a write-one clear
	// so an edge landing on the clear cycle is never lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q
				& ~(reg_wr(wr_en, addr, `PCG_IRQ_STAT) ? wdat : '0))
				| ((pin_q ^ pin_prev_q) & irq_en_q);
		end
	end

	// ------------------------------------------------------------
	// Pad drive and controls, registered so outputs come from flops
	// ------------------------------------------------------------
	generate
		for (gi = 0; gi < `PCG_NPINS; gi++) begin : g_drv
			logic gpio;
			logic drv;
			logic oe;
			logic rep;
			logic raw;
			assign gpio = pad_q[gi].pin_function_select == 3'h0;
			// Repeater follows the raw pad level, not the inverted one
			assign raw = in_sync_q[gi];
			assign drv = gpio ? out_q[gi] : periph_out[gi];
			// Open drain: only drive low
			always_comb begin
				if (gpio) begin
					oe = dir_q[gi];
				end else begin
					oe = periph_oe[gi];
				end
				if (gpio && pad_q[gi].open_drain) begin
					oe = dir_q[gi] && !out_q[gi];
				end
				if (!gpio && is_bus(gi)) begin
					oe = periph_oe[gi] && !periph_out[gi];
				end
			end
			// Repeater stops holding while in deep power-down
			assign rep = pad_q[gi].pull == pcg_pkg::PCG_REPEATER && !deep_pdn;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pad_out[gi] <= 1'b0;
					pad_oe[gi] <= 1'b0;
					pad_ctl[gi] <= '0;
					periph_in[gi] <= 1'b0;
					periph_sel[gi] <= 1'b0;
				end else begin
					pad_out[gi] <= drv;
					pad_oe[gi] <= oe;
					pad_ctl[gi].pull_up_en <= (pad_q[gi].pull
						== pcg_pkg::PCG_PULL_UP) || (rep && raw);
					pad_ctl[gi].pull_down_en <= (pad_q[gi].pull
						== pcg_pkg::PCG_PULL_DOWN) || (rep && !raw);
					pad_ctl[gi].filter_en <= bus_filt(gi, pad_q[gi]);
					pad_ctl[gi].hysteresis <= pad_q[gi].hysteresis;
					pad_ctl[gi].sink_mode <= pad_q[gi].sink_mode;
					pad_ctl[gi].sink_level <= drv
						? pad_q[gi].sink_current_high_level
						: pad_q[gi].sink_current_low_level;
					periph_in[gi] <= gpio ? 1'b0 : pin_q[gi];
					periph_sel[gi] <= !gpio;
				end
			end
		end
	endgenerate

	// Interrupt and wake lines
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_irq <= 1'b0;
			wake_irq <= '0;
		end else begin
			port_irq <= |irq_stat_q;
			wake_irq <= pin_q[`PCG_NWAKE-1:0];
		end
	end

	// ------------------------------------------------------------
	// APB read mux and response
	// ------------------------------------------------------------
	always_comb begin
		rdata_d = 32'h0000_0000;
		hit = 1'b1;
		unique case (addr)
			`PCG_PORT_DATA: rdata_d[`PCG_NPINS-1:0] = pin_q;
			`PCG_PORT_MASK: rdata_d[`PCG_NPINS-1:0] = mask_q;
			`PCG_PORT_MDATA: rdata_d[`PCG_NPINS-1:0] = pin_q & ~mask_q;
			`PCG_PORT_SET: rdata_d[`PCG_NPINS-1:0] = out_q;
			`PCG_PORT_DIR: rdata_d[`PCG_NPINS-1:0] = dir_q;
			`PCG_IRQ_EN: rdata_d[`PCG_NPINS-1:0] = irq_en_q;
			`PCG_IRQ_STAT: rdata_d[`PCG_NPINS-1:0] = irq_stat_q;
			`PCG_PORT_CLR, `PCG_PORT_TGL, `PCG_DIR_SET, `PCG_DIR_CLR,
			`PCG_DIR_TGL: rdata_d = 32'h0000_0000;
			default: begin
				hit = 1'b0;
				for (int i = 0; i < `PCG_NPINS; i++) begin
					if (addr == 12'(`PCG_PAD_BASE + i * 4)) begin
						rdata_d[`PCG_PAD_BITS-1:0] = pad_q[i];
						hit = 1'b1;
					end
				end
			end
		endcase
	end

	// Read data latched in setup; pready stays high so access is one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			// No wait states: every access finishes in its first cycle
			pready <= 1'b1;
			pslverr <= psel && !penable && !hit;
			// A refused access of either direction leaves zero read data
			if (rd_en || (psel && !penable && !hit)) begin
				prdata <= rdata_d;
			end
		end
	end

endmodule : pcg_top

`default_nettype wire

// ### test/pcg_chk.sv
// Assertion checker for the pad and port block
`timescale 1ns/10ps
`default_nettype none
module pcg_chk (
	// Clock, reset and bus answer
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pads and peripherals
	input wire logic [11:0] pad_in,
	input wire logic [11:0] pad_out,
	input wire logic [11:0] pad_oe,
	input wire pcg_pkg::pcg_padctl_s [11:0] pad_ctl,
	input wire logic [11:0] periph_out,
	input wire logic [11:0] periph_oe,
	input wire logic [11:0] periph_in,
	input wire logic [11:0] periph_sel,
	input wire logic [10:0] wake_irq
);
	logic [11:0] up_w;
	logic [11:0] dn_w;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Pull enables gathered per pad
	for (genvar i = 0; i < 12; i++) begin : g_pull
		assign up_w[i] = pad_ctl[i].pull_up_en;
		assign dn_w[i] = pad_ctl[i].pull_down_en;
	end
	// Pins still long enough to clear the sampler
	sequence s_pins_still;
		(presetn && $stable(pad_in))[*4];
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	// Setup cycle aimed at a page with no registers
	sequence s_unmapped;
		psel && !penable && (paddr[11:8] == 4'h2);
	endsequence
	a_err_unmapped: assert property (s_unmapped |=> pslverr)
		else $error("unmapped access not refused");
	a_ready_access: assert property (s_access |-> pready)
		else $error("pready low in access phase");
	a_ready_after: assert property ($past(presetn) |-> pready)
		else $error("pready low after reset");
	a_err_access: assert property (pslverr |-> s_access)
		else $error("pslverr outside access");
	a_err_zero: assert property (pslverr |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_gpio_no_in: assert property ((periph_in & ~periph_sel) == 12'h0)
		else $error("port pin feeds peripheral");
	a_periph_dir: assert property (periph_sel[0] && $past(periph_sel[0])
		|-> pad_oe[0] == $past(periph_oe[0])
		&& pad_out[0] == $past(periph_out[0]))
		else $error("peripheral drive not followed");
	// Bus pads skipped: their filter adds delay
	a_wake_pins: assert property (s_pins_still
		|-> ((wake_irq ^ pad_in[10:0]) & 11'h7CF) == 11'h0)
		else $error("wake line differs from pin");
	a_pull_excl: assert property ((up_w & dn_w) == 12'h0)
		else $error("both pulls on");
endmodule : pcg_chk

bind pcg_top pcg_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr),
	.prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
	.pad_oe(pad_oe), .pad_ctl(pad_ctl), .periph_out(periph_out),
	.periph_oe(periph_oe), .periph_in(periph_in),
	.periph_sel(periph_sel), .wake_irq(wake_irq));
`default_nettype wire

// ### test/pcg_top_tb_top.sv
// Self-checking bench for the pad and port block
`timescale 1ns/10ps
`default_nettype none
module pcg_top_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [11:0] pad_in = 12'h0;
	logic [11:0] periph_out = 12'h0;
	logic [11:0] periph_oe = 12'h0;
	logic deep_pdn = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [11:0] pad_out;
	logic [11:0] pad_oe;
	logic [11:0] periph_in;
	logic [11:0] periph_sel;
	logic [10:0] wake_irq;
	logic port_irq;
	pcg_pkg::pcg_padctl_s [11:0] pad_ctl;
	logic [31:0] rnd = 32'hB22E;
	logic [31:0] exp_q[$];
	int err_total = 0;
	int check_count = 0;
	localparam logic [31:0] CFG [4] = '{32'h10, 32'h08, 32'h20, 32'h18};
	localparam logic [9:0] CTL [4] = '{10'h200, 10'h100, 10'h040, 10'h100};

	pcg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_ctl(pad_ctl), .periph_out(periph_out), .periph_oe(periph_oe),
		.periph_in(periph_in), .periph_sel(periph_sel),
		.deep_pdn(deep_pdn), .wake_irq(wake_irq), .port_irq(port_irq));

	// Bus clock, 8 ns period
	always #4 pclk = ~pclk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk

	// Holds the request until pready is seen, no cycle count assumed
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd

	// Oldest note taken as each read completes
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite)
			chk("prdata", exp_q.pop_front(), prdata);
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test

	// Watchdog, far beyond the expected run
	initial begin
		#200000;
		err_total++;
		finish_test();
	end

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 12; i++)
			rd(12'(4 * i), (i inside {4, 5, 10, 11}) ? 32'h1 : 32'h0);
		rd(12'h118, 32'h0);
		$display("reset test done");
		// Whole, set, clear, toggle and masked writes
		wr(12'h118, 32'hFFF);
		wr(12'h100, 32'hA5A);
		wr(12'h10C, 32'h005);
		rd(12'h10C, 32'hA5F);
		wr(12'h110, 32'h00F);
		wr(12'h114, 32'h0FF);
		rd(12'h10C, 32'hAAF);
		wr(12'h104, 32'hF00);
		wr(12'h108, 32'h000);
		rd(12'h10C, 32'hA00);
		chk("pad_out", 32'h200, 32'(pad_out & 12'h3CF));
		chk("pad_oe", 32'h3CF, 32'(pad_oe & 12'h3CF));
		wr(12'h120, 32'h00F);
		wr(12'h124, 32'h030);
		wr(12'h11C, 32'h001);
		rd(12'h118, 32'hFC1);
		chk("pad_oe", 32'h3C1, 32'(pad_oe & 12'h3CF));
		wr(12'h000, 32'h080);
		repeat (2) @(posedge pclk);
		chk("od low", 32'h1, 32'(pad_oe[0]));
		wr(12'h10C, 32'h001);
		repeat (2) @(posedge pclk);
		chk("od high", 32'h0, 32'(pad_oe[0]));
		wr(12'h118, 32'h0);
		wr(12'h104, 32'h0);
		$display("port test done");
		// Random pin levels read back
		for (int k = 0; k < 8; k++) begin
			rnd = lfsr(rnd);
			pad_in <= rnd[11:0];
			periph_out <= rnd[23:12];
			periph_oe <= rnd[31:20];
			repeat (12) @(posedge pclk);
			rd(12'h100, {20'h0, rnd[11:0]});
		end
		pad_in <= 12'h0;
		// Pull modes on pad 0, repeater last
		for (int j = 0; j < 4; j++) begin
			wr(12'h000, CFG[j]);
			repeat (4) @(posedge pclk);
			chk("pad_ctl", 32'(CTL[j]), 32'(pad_ctl[0]));
		end
		pad_in <= 12'h001;
		repeat (5) @(posedge pclk);
		chk("keeper", 32'h200, 32'(pad_ctl[0]));
		deep_pdn <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("pdn pull", 32'h0, 32'(pad_ctl[0]));
		deep_pdn <= 1'b0;
		$display("pull test done");
		// Peripheral routing, sink and bus pad modes
		wr(12'h000, 32'h1);
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			periph_oe <= rnd[11:0];
			periph_out <= rnd[12:1];
			@(posedge pclk);
		end
		chk("periph_sel", 32'h1, 32'(periph_sel[0]));
		chk("filter", 32'h1, 32'(pad_ctl[4].filter_en));
		wr(12'h00C, 32'h92C00);
		wr(12'h010, 32'h101);
		repeat (4) @(posedge pclk);
		chk("sink", 32'h1, 32'(pad_ctl[3].sink_mode));
		chk("sink lvl", 32'h05, 32'(pad_ctl[3].sink_level));
		wr(12'h10C, 32'h008);
		repeat (2) @(posedge pclk);
		chk("sink lvl", 32'h09, 32'(pad_ctl[3].sink_level));
		chk("filter", 32'h0, 32'(pad_ctl[4].filter_en));
		$display("pad test done");
		// Port interrupt raised and cleared
		wr(12'h000, 32'h0);
		wr(12'h128, 32'h001);
		wr(12'h12C, 32'hFFF);
		repeat (3) @(posedge pclk);
		chk("port_irq", 32'h0, 32'(port_irq));
		pad_in <= 12'h000;
		for (int i = 0; i < 10 && port_irq !== 1'b1; i++) @(posedge pclk);
		chk("port_irq", 32'h1, 32'(port_irq));
		wr(12'h12C, 32'h001);
		repeat (3) @(posedge pclk);
		chk("port_irq", 32'h0, 32'(port_irq));
		rd(12'h200, 32'h0);
		$display("irq test done");
		repeat (2) @(posedge pclk);
		finish_test();
	end
endmodule : pcg_top_tb_top
`default_nettype wire
